// file: pkg/ssps_pkg.sv
// Constants, types and helpers of the soft-start and protection sequencer

package ssps_pkg;

	// ----------------------------------------
	// Widths and soft start
	// ----------------------------------------
	localparam int REF_W = 12;
	localparam int CNT_W = 12;
	localparam int PROD_W = 20;
	localparam int SS_SHIFT = 11;
	localparam logic [CNT_W-1:0] SS_STEPS = 12'h800;
	localparam logic [CNT_W-1:0] SS_LAST = 12'h7FF;
	// Sense and reference are 1 mV per LSB, so 0.6V is 600
	localparam logic [REF_W-1:0] UV_EN_REF = 12'h258;

	// ----------------------------------------
	// Thresholds in percent
	// ----------------------------------------
	localparam logic [7:0] PCT_FULL = 8'h64;
	localparam logic [7:0] PCT_PG_LO = 8'h58;
	localparam logic [7:0] PCT_PG_HI = 8'h70;
	localparam logic [7:0] PCT_UV = 8'h3C;
	localparam logic [7:0] PCT_OV = 8'h7D;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
	localparam logic [7:0] ADDR_RAMP = 8'h0C;
	localparam logic [4:0] IRQ_MASK_RST = 5'h00;
	localparam int EV_UV = 0;
	localparam int EV_OV = 1;
	localparam int EV_SS_DONE = 2;
	localparam int EV_SUPPLY_OFF = 3;
	localparam int EV_PG_LOST = 4;
	localparam int EV_W = 5;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {ST_OFF, ST_SOFT, ST_RUN, ST_UV, ST_OV} ssps_state_t;

	typedef struct packed {
		logic [1:0] high_side;
		logic [1:0] low_side;
	} ssps_gate_t;

	localparam ssps_gate_t GATE_OFF = '{high_side: 2'h0, low_side: 2'h0};
	localparam ssps_gate_t GATE_SWITCH = '{high_side: 2'h3, low_side: 2'h3};
	localparam ssps_gate_t GATE_CROWBAR = '{high_side: 2'h0, low_side: 2'h3};

	// Percent scaling, used by every window comparator
	function automatic logic [PROD_W-1:0] scale(input logic [REF_W-1:0] v,
		input logic [7:0] p);
		scale = PROD_W'(v) * PROD_W'(p);
	endfunction

endpackage

// file: verilog/ssps_top.sv
// Soft-start and protection sequencer with an AHB-Lite register slave
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module ssps_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic ctrl_supply_ok,
	input wire logic driver_supply_ok,
	input wire logic output_enable_input,
	input wire logic [ssps_pkg::REF_W-1:0] programmed_reference,
	input wire logic [ssps_pkg::REF_W-1:0] sensed_output_voltage,
	output logic [ssps_pkg::REF_W-1:0] loop_reference,
	output ssps_pkg::ssps_gate_t gate_enable,
	output logic output_in_window_flag,
	output logic pg_pin_o,
	output logic pg_pin_oe,
	output logic fault_latched_output,
	output logic irq
);
	import ssps_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	ssps_state_t state_q;
	ssps_state_t state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic uv_low_q;
	logic output_in_window_flag_q;
	logic output_in_window_flag_d;
	logic fault_q;
	ssps_gate_t gate_q;
	ssps_gate_t gate_d;
	logic [REF_W-1:0] ref_q;
	logic [EV_W-1:0] stat_q;
	logic [EV_W-1:0] mask_q;
	logic [EV_W-1:0] ev;

	// ----------------------------------------
	// Ramp reference
	// ----------------------------------------
	wire logic [23:0] ramp_prod;
	wire logic [REF_W-1:0] ramp_ref;
	wire logic ss_last;

	// Reference scales the programmed value by cnt/2048
	assign ramp_prod = 24'(programmed_reference) * 24'(cnt_q);
	assign ramp_ref = ramp_prod[SS_SHIFT+REF_W-1:SS_SHIFT];
	assign ss_last = (cnt_q == SS_LAST);

	// ----------------------------------------
	// Comparators
	// ----------------------------------------
	wire logic [PROD_W-1:0] sense_pct;
	wire logic uv_low;
	wire logic uv_armed;
	wire logic ov_hit;
	wire logic in_win;
	wire logic supplies_ok;
	wire logic active;
	wire logic prot_on;
	wire logic uv_cand;
	wire logic uv_trip;
	wire logic ov_trip;

	assign sense_pct = scale(sensed_output_voltage, PCT_FULL);
	// Under-voltage follows the rising ramp, over-voltage the final value
	assign uv_low = sense_pct < scale(ramp_ref, PCT_UV);
	assign ov_hit = sense_pct >= scale(programmed_reference, PCT_OV);
	assign uv_armed = (ramp_ref >= UV_EN_REF);
	assign in_win = (sense_pct >= scale(programmed_reference, PCT_PG_LO))
		&& (sense_pct <= scale(programmed_reference, PCT_PG_HI));

	assign supplies_ok = ctrl_supply_ok && driver_supply_ok;
	assign active = (state_q == ST_SOFT) || (state_q == ST_RUN);
	// Protections live in soft start too, but die with the enable
	assign prot_on = active && output_enable_input;
	assign uv_cand = prot_on && uv_armed && uv_low;
	// One low sample is a glitch; two in a row is a fault
	assign uv_trip = uv_cand && uv_low_q;
	// Armed by the main supply alone, so a rail already high before soft start trips too
	assign ov_trip = ov_hit && ctrl_supply_ok && output_enable_input
		&& (state_q != ST_UV);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			ST_OFF: begin
				if (ov_trip) begin
					state_d = ST_OV;
				end else if (supplies_ok && output_enable_input) begin
					state_d = (cnt_q == SS_STEPS) ? ST_RUN : ST_SOFT;
				end
			end
			ST_SOFT, ST_RUN: begin
				if (ov_trip) begin
					state_d = ST_OV;
				end else if (uv_trip) begin
					state_d = ST_UV;
				end else if (!supplies_ok) begin
					state_d = ST_OFF;
				end else if (!output_enable_input) begin
					state_d = ST_OFF;
				end else if (state_q == ST_SOFT) begin
					cnt_d = cnt_q + 12'h001;
					if (ss_last) begin
						state_d = ST_RUN;
					end
				end
			end
			// Only the power-on reset leaves a fault state
			ST_UV: state_d = ST_UV;
			ST_OV: state_d = ST_OV;
			default: state_d = ST_OFF;
		endcase
	end

	// ----------------------------------------
	// Gate drive, power-good, fault
	// ----------------------------------------
	wire logic run_d;

	assign run_d = (state_d == ST_SOFT) || (state_d == ST_RUN);

	always_comb begin
		gate_d = GATE_OFF;
		if (!output_enable_input) begin
			gate_d = GATE_OFF;
		end else if (state_d == ST_OV) begin
			gate_d = GATE_CROWBAR;
		end else if (run_d) begin
			gate_d = GATE_SWITCH;
		end
	end

	assign output_in_window_flag_d = (state_d == ST_RUN) && in_win && output_enable_input;

	// ----------------------------------------
	// Events
	// ----------------------------------------
	assign ev[EV_UV] = (state_d == ST_UV) && (state_q != ST_UV);
	assign ev[EV_OV] = (state_d == ST_OV) && (state_q != ST_OV);
	assign ev[EV_SS_DONE] = (state_q == ST_SOFT) && (state_d == ST_RUN);
	assign ev[EV_SUPPLY_OFF] = active && (state_d == ST_OFF) && !supplies_ok;
	assign ev[EV_PG_LOST] = output_in_window_flag_q && !output_in_window_flag_d;

	// ----------------------------------------
	// Core flops
	// ----------------------------------------
	// Reset alone clears faults and ramp; power-good also clears on leaving run or the window
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_OFF;
			cnt_q <= '0;
			uv_low_q <= 1'b0;
			output_in_window_flag_q <= 1'b0;
			fault_q <= 1'b0;
			gate_q <= GATE_OFF;
			ref_q <= '0;
		end else if (clk_en) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			uv_low_q <= uv_cand;
			output_in_window_flag_q <= output_in_window_flag_d;
			fault_q <= (state_d == ST_UV) || (state_d == ST_OV);
			gate_q <= gate_d;
			ref_q <= ramp_ref;
		end
	end

	assign gate_enable = gate_q;
	assign loop_reference = ref_q;
	assign fault_latched_output = fault_q;
	assign output_in_window_flag = output_in_window_flag_q;
	// Open drain: pulls low unless power is good
	assign pg_pin_o = 1'b0;
	assign pg_pin_oe = !output_in_window_flag_q;

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	logic dp_wr_q;
	logic [7:0] dp_addr_q;
	logic [31:0] rdata_q;
	wire logic ap_take;
	wire logic [7:0] ap_addr;
	wire logic [31:0] status_word;
	wire logic [31:0] rd_mux;
	wire logic wr_stat;
	wire logic wr_mask;
	wire logic [EV_W-1:0] clr;

	// Frozen clock enable stalls the bus rather than dropping a transfer
	assign hreadyout = clk_en;
	assign hresp = 1'b0;
	assign ap_take = hsel && htrans[1] && hready;
	assign ap_addr = haddr[7:0];

	assign status_word = {24'h0, driver_supply_ok, ctrl_supply_ok,
		fault_q, output_in_window_flag_q, output_enable_input, state_q};
	assign rd_mux = (ap_addr == ADDR_STATUS) ? status_word :
		(ap_addr == ADDR_IRQ_STAT) ? {27'h0, stat_q} :
		(ap_addr == ADDR_IRQ_MASK) ? {27'h0, mask_q} :
		(ap_addr == ADDR_RAMP) ? {20'h0, cnt_q} : 32'h0;

	assign wr_stat = dp_wr_q && (dp_addr_q == ADDR_IRQ_STAT);
	assign wr_mask = dp_wr_q && (dp_addr_q == ADDR_IRQ_MASK);
	assign clr = wr_stat ? hwdata[EV_W-1:0] : '0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q <= 1'b0;
			dp_addr_q <= 8'h00;
			rdata_q <= 32'h0;
		end else if (clk_en) begin
			dp_wr_q <= ap_take && hwrite;
			dp_addr_q <= ap_addr;
			rdata_q <= (ap_take && !hwrite) ? rd_mux : 32'h0;
		end
	end

	assign hrdata = rdata_q;

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	// Set wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_q <= '0;
			mask_q <= IRQ_MASK_RST;
		end else if (clk_en) begin
			stat_q <= (stat_q & ~clr) | ev;
			if (wr_mask) begin
				mask_q <= hwdata[EV_W-1:0];
			end
		end
	end

	assign irq = |(stat_q & mask_q);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_uv_two;
		(clk_en && uv_cand) ##1 (clk_en && uv_cand);
	endsequence

	sequence s_ss_end;
		clk_en && state_q == ST_SOFT && ss_last && !ov_trip && !uv_trip
			&& supplies_ok && output_enable_input;
	endsequence

	property p_pg_window;
		clk_en && !in_win |=> !output_in_window_flag && pg_pin_oe;
	endproperty
	a_pg_window: assert property (p_pg_window)
		else $error("power-good high outside window");

	property p_pg_soft;
		state_q == ST_SOFT |-> !output_in_window_flag;
	endproperty
	a_pg_soft: assert property (p_pg_soft)
		else $error("power-good high during soft start");

	property p_ss_end;
		s_ss_end |=> state_q == ST_RUN && cnt_q == SS_STEPS
			&& loop_reference == $past(ramp_ref);
	endproperty
	a_ss_end: assert property (p_ss_end)
		else $error("soft start did not end after 2048 steps");

	property p_uv_trip;
		s_uv_two |=> (state_q == ST_UV || state_q == ST_OV) && fault_latched_output;
	endproperty
	a_uv_trip: assert property (p_uv_trip)
		else $error("under-voltage not tripped after two low cycles");

	property p_uv_hold;
		state_q == ST_UV |=> state_q == ST_UV && fault_latched_output
			&& gate_enable == GATE_OFF;
	endproperty
	a_uv_hold: assert property (p_uv_hold)
		else $error("under-voltage latch released");

	property p_ov_crowbar;
		clk_en && ov_trip && output_enable_input |=>
			state_q == ST_OV && gate_enable == GATE_CROWBAR && fault_latched_output;
	endproperty
	a_ov_crowbar: assert property (p_ov_crowbar)
		else $error("over-voltage crowbar missing");

	property p_uv_ignore;
		clk_en && active && ramp_ref < UV_EN_REF && !ov_hit |=> state_q != ST_UV;
	endproperty
	a_uv_ignore: assert property (p_uv_ignore)
		else $error("under-voltage acted below 0.6V");

	property p_start_gate;
		state_q == ST_OFF && !supplies_ok && !ov_trip |=> state_q == ST_OFF;
	endproperty
	a_start_gate: assert property (p_start_gate)
		else $error("soft start without both supplies");

	property p_disable;
		clk_en && !output_enable_input |=> gate_enable == GATE_OFF
			&& !output_in_window_flag;
	endproperty
	a_disable: assert property (p_disable)
		else $error("switches on while disabled");

	property p_supply_loss;
		clk_en && active && !supplies_ok && !ov_trip && !uv_trip |=>
			state_q == ST_OFF && gate_enable == GATE_OFF;
	endproperty
	a_supply_loss: assert property (p_supply_loss)
		else $error("no shutdown on supply loss");

	sequence s_ov_seen;
		clk_en && ov_hit && ctrl_supply_ok && output_enable_input && state_q != ST_UV;
	endsequence

	property p_ov_arm;
		s_ov_seen |=> state_q == ST_OV && fault_latched_output;
	endproperty
	a_ov_arm: assert property (p_ov_arm)
		else $error("over-voltage not armed by main supply");

	property p_soft_switch;
		clk_en && state_q == ST_OFF && supplies_ok && output_enable_input && !ov_trip
			|=> state_q == ST_SOFT || state_q == ST_RUN;
	endproperty
	a_soft_switch: assert property (p_soft_switch)
		else $error("soft start did not begin");

	property p_run_gates;
		clk_en && state_q == ST_RUN && supplies_ok && output_enable_input
			&& !ov_trip && !uv_trip |=> gate_enable == GATE_SWITCH;
	endproperty
	a_run_gates: assert property (p_run_gates)
		else $error("switching stopped while supplies good");

	property p_ov_over_uv;
		clk_en && ov_trip && uv_trip |=> state_q == ST_OV;
	endproperty
	a_ov_over_uv: assert property (p_ov_over_uv)
		else $error("under-voltage taken over over-voltage");

	property p_fault_hold;
		fault_latched_output |=> fault_latched_output;
	endproperty
	a_fault_hold: assert property (p_fault_hold)
		else $error("fault output released without reset");

	property p_pg_needs_run;
		output_in_window_flag |-> state_q == ST_RUN;
	endproperty
	a_pg_needs_run: assert property (p_pg_needs_run)
		else $error("power-good high outside run state");

	// Frozen enable must hold the state, interrupt status and gate drive, not just the ramp
	property p_freeze;
		!clk_en |=> $stable(state_q) && $stable(cnt_q) && $stable(stat_q)
			&& $stable(gate_q);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// file: sim/ssps_rail_model.sv
// Behavioural model of the power switches and the monitored output rail
`timescale 1ns/1ns
`default_nettype none

module ssps_rail_model (
	input wire logic hclk,
	input wire ssps_pkg::ssps_gate_t gate_enable,
	input wire logic [ssps_pkg::REF_W-1:0] loop_reference,
	input wire logic force_en,
	input wire logic [ssps_pkg::REF_W-1:0] force_val,
	output logic [ssps_pkg::REF_W-1:0] sensed_output_voltage
);
	import ssps_pkg::*;

	// ----------------------------------------
	// Rail
	// ----------------------------------------
	initial sensed_output_voltage = '0;

	// Forcing stands in for load steps and faults on the rail
	// Crowbar pulls the rail down; with all switches off it only sags slowly
	always @(posedge hclk) begin
		if (force_en) begin
			sensed_output_voltage <= force_val;
		end else if (gate_enable.high_side != 2'h0) begin
			sensed_output_voltage <= loop_reference;
		end else if (gate_enable.low_side != 2'h0) begin
			sensed_output_voltage <= '0;
		end else begin
			sensed_output_voltage <= sensed_output_voltage - (sensed_output_voltage >> 4);
		end
	end

endmodule

`default_nettype wire

// file: sim/tb_ssps_top.sv
// Self-checking bench of the soft-start and protection sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: got %0h want %0h", $time, a, e); end end

module tb_ssps_top;
	import ssps_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, pg, pg_o, pg_oe;
	logic fault, ctrl_ok, drv_ok, en, f_en, ce;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [REF_W-1:0] prog, sensed, lr, f_val;
	logic [REF_W-1:0] wv [4];
	logic [15:0] lfsr;
	ssps_gate_t gate;
	int error_cnt, check_count, n, k, lr_prev;

	assign hready = hreadyout;

	ssps_top u_ssps_top (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_en(ce),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(3'h2),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.ctrl_supply_ok(ctrl_ok),
		.driver_supply_ok(drv_ok),
		.output_enable_input(en),
		.programmed_reference(prog),
		.sensed_output_voltage(sensed),
		.loop_reference(lr),
		.gate_enable(gate),
		.output_in_window_flag(pg),
		.pg_pin_o(pg_o),
		.pg_pin_oe(pg_oe),
		.fault_latched_output(fault),
		.irq(irq)
	);

	ssps_rail_model u_ssps_rail_model (
		.hclk(hclk),
		.gate_enable(gate),
		.loop_reference(lr),
		.force_en(f_en),
		.force_val(f_val),
		.sensed_output_voltage(sensed)
	);

	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic results;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge hclk);
		#1;
	endtask

	// Bounded wait; a stuck bus ends the run
	task automatic wait_rdy;
		int w;
		w = 0;
		do begin
			@(posedge hclk);
			w++;
		end while (hready !== 1'b1 && w < 64);
		if (w >= 64) begin
			error_cnt++;
			results();
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		#1;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		`CHK(rd & m, e)
		`CHK(hresp, 1'b0)
	endtask

	task automatic do_reset;
		lfsr = lfsr_next(lfsr);
		@(posedge hclk);
		hresetn <= 1'b0;
		ctrl_ok <= 1'b0;
		drv_ok <= 1'b0;
		// Rail held at zero through reset so no stale level meets the new start
		f_en <= 1'b1;
		f_val <= '0;
		prog <= REF_W'(1000 + int'(lfsr % 601));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		f_en <= 1'b0;
		cyc(1);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		ctrl_ok = 1'b0;
		drv_ok = 1'b0;
		en = 1'b1;
		ce = 1'b1;
		f_en = 1'b0;
		f_val = '0;
		prog = '0;
		lfsr = 16'h0047;
		error_cnt = 0;
		check_count = 0;
		do_reset();
		`CHK({gate, pg, pg_o, pg_oe, fault, irq}, 9'h004)
		rchk(ADDR_STATUS, 32'hFF, 32'h08);
		rchk(ADDR_RAMP, 32'hFFFFFFFF, 32'h0);
		rchk(ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
		rchk(8'h40, 32'hFFFFFFFF, 32'h0);
		@(posedge hclk);
		ctrl_ok <= 1'b1;
		cyc(8);
		`CHK(gate, GATE_OFF)
		@(posedge hclk);
		drv_ok <= 1'b1;
		f_en <= 1'b1;
		cyc(2);
		`CHK(gate, GATE_SWITCH)
		cyc(100);
		`CHK(fault, 1'b0)
		@(posedge hclk);
		ce <= 1'b0;
		cyc(1);
		k = lr;
		cyc(10);
		`CHK(lr, k)
		`CHK(hreadyout, 1'b0)
		@(posedge hclk);
		ce <= 1'b1;
		@(posedge hclk);
		f_en <= 1'b0;
		cyc(1300);
		// Between the ramp and final thresholds: neither trip may fire
		for (n = 0; n < 2; n++) begin
			@(posedge hclk);
			f_en <= 1'b1;
			f_val <= REF_W'(int'(lr) * (n == 0 ? 61 : 130) / 100);
			cyc(12);
			`CHK(fault, 1'b0)
		end
		@(posedge hclk);
		f_val <= REF_W'(int'(lr) * 59 / 100);
		cyc(5);
		`CHK({gate, fault}, 5'h01)
		@(posedge hclk);
		f_val <= 12'hFFF;
		en <= 1'b0;
		cyc(4);
		@(posedge hclk);
		en <= 1'b1;
		cyc(4);
		`CHK({gate, fault}, 5'h01)
		rchk(ADDR_STATUS, 32'h27, 32'h23);
		do_reset();
		`CHK(fault, 1'b0)
		@(posedge hclk);
		ctrl_ok <= 1'b1;
		drv_ok <= 1'b1;
		cyc(2);
		lr_prev = 0;
		for (n = 1; n < 2100 && pg !== 1'b1; n++) begin
			`CHK(pg, 1'b0)
			`CHK(lr >= lr_prev && lr <= prog, 1'b1)
			lr_prev = lr;
			cyc(1);
		end
		`CHK(n, 2048)
		rchk(ADDR_RAMP, 32'hFFFFFFFF, 32'h800);
		`CHK(lr, prog)
		rchk(ADDR_STATUS, 32'hFF, 32'hDA);
		rchk(ADDR_IRQ_STAT, 32'h1F, 32'h04);
		`CHK(irq, 1'b0)
		ahb(1'b1, ADDR_IRQ_MASK, 32'h1F);
		`CHK(irq, 1'b1)
		ahb(1'b1, ADDR_IRQ_STAT, 32'h04);
		`CHK(irq, 1'b0)
		wv[0] = REF_W'(int'(prog) * 112 / 100 + 1);
		wv[1] = REF_W'(int'(prog) * 112 / 100);
		wv[2] = REF_W'((int'(prog) * 88 + 99) / 100 - 1);
		wv[3] = REF_W'((int'(prog) * 88 + 99) / 100);
		for (n = 0; n < 4; n++) begin
			@(posedge hclk);
			f_en <= 1'b1;
			f_val <= wv[n];
			cyc(3);
			`CHK(pg, n[0])
		end
		`CHK(irq, 1'b1)
		rchk(ADDR_IRQ_STAT, 32'h1F, 32'h10);
		// A single low sample must not trip
		@(posedge hclk);
		f_val <= '0;
		@(posedge hclk);
		f_en <= 1'b0;
		cyc(4);
		`CHK(fault, 1'b0)
		for (n = 0; n < 2; n++) begin
			@(posedge hclk);
			drv_ok <= n[0];
			ctrl_ok <= ~n[0];
			cyc(2);
			`CHK(gate, GATE_OFF)
			@(posedge hclk);
			drv_ok <= 1'b1;
			ctrl_ok <= 1'b1;
			cyc(3);
			`CHK(gate, GATE_SWITCH)
		end
		@(posedge hclk);
		en <= 1'b0;
		f_en <= 1'b1;
		f_val <= '0;
		cyc(20);
		`CHK({gate, fault}, 5'h00)
		@(posedge hclk);
		f_val <= prog;
		cyc(2);
		@(posedge hclk);
		en <= 1'b1;
		cyc(3);
		`CHK({gate, fault}, 5'h1E)
		// Trip armed by the main supply alone, then inside soft start
		for (k = 0; k < 2; k++) begin
			do_reset();
			@(posedge hclk);
			ctrl_ok <= 1'b1;
			drv_ok <= k[0];
			f_en <= 1'b1;
			f_val <= REF_W'((int'(prog) * 125 + 99) / 100 - 1);
			cyc(20);
			`CHK(fault, 1'b0)
			@(posedge hclk);
			f_val <= REF_W'((int'(prog) * 125 + 99) / 100);
			cyc(3);
			`CHK({gate, fault}, 5'h07)
			@(posedge hclk);
			f_val <= '0;
			cyc(6);
			`CHK({gate, fault}, 5'h07)
			rchk(ADDR_STATUS, 32'h27, 32'h24);
		end
		results();
	end

endmodule

`default_nettype wire
